// >>> rtl/sar_adc_control_powerfail.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// [RULE_01] two-bit channel field routes one of four analog inputs
// [RULE_02] while enabled, selected channel converts repeatedly to an 8-bit result
// [RULE_03] normal mode raises conversion-done request after every conversion
// [RULE_04] power-fail mode raises request only when threshold comparison holds
// [RULE_05] approximation resolves from msb; after lsb result is transferred
// [RULE_06] result register loads each conversion end; read-only whole byte
// [RULE_07] reset clears the conversion result to zero
// [RULE_08] writing mode or channel leaves the result undefined; read first
// [RULE_09] mode bit 7 stops (0) or enables (1) conversion
// [RULE_10] mode bits 5..3 choose 144,120,96,288,240,192 clock conversion time
// [RULE_11] software picks a time code giving at least 15 us; at the 5 ns clock no code does, the longest (288 periods) gives 1.44 us
// [RULE_12] mode register resets to zero; bit and byte writes accepted
// [RULE_13] channel register resets to zero; byte writes only
// [RULE_14] software writes zero to mode bits 0..2 and 6
// [RULE_15] software writes zero to channel bits 2..7
// [RULE_16] the four analog pins also read back as digital inputs
// [RULE_17] power-fail enable selects normal or threshold-gated mode
// [RULE_18] direction 0: request if result >= threshold; 1: if below
// [RULE_19] eight-bit threshold register, reset to zero, feeds the comparison
// [RULE_20] mode or channel write aborts conversion; restarts if still enabled
// [RULE_21] one approximation bit per equal share of the conversion time
// [RULE_22] clock cycles counted against duration, reloaded at each start
module sar_adc_control_powerfail (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic comparator_high,
  input wire logic analog_in_0,
  input wire logic analog_in_1,
  input wire logic analog_in_2,
  input wire logic analog_in_3,
  output logic [1:0] channel_sel,
  output logic [7:0] tap_code,
  output logic sample_hold,
  output logic conversion_done_irq
);

  // reset release through two flops
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // comparator and pin levels come from outside the clock domain
  logic [4:0] async_in;
  logic [4:0] sync2;
  assign async_in = {comparator_high, analog_in_3, analog_in_2,
                     analog_in_1, analog_in_0};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gen_sync
      logic stage1;
      logic stage2;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[g];
          stage2 <= stage1;
        end
      end
      // only the second stage leaves the loop
      assign sync2[g] = stage2;
    end
  endgenerate

  // avalon slave: one wait cycle, answer on the second cycle
  logic ack;
  logic req;
  logic acc;
  logic [15:0] idx;
  assign req = read || write;
  assign waitrequest = req && !ack;
  assign acc = req && ack;
  assign idx = address[17:2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  logic wr_lo;
  logic wr_mode;
  logic wr_mode_bit;
  logic wr_chan;
  logic wr_pf;
  logic wr_thresh;
  assign wr_lo = acc && write && byteenable[0];
  assign wr_mode = wr_lo && (idx == sar_adc_pkg::IDX_MODE);
  assign wr_mode_bit = wr_lo && (idx == sar_adc_pkg::IDX_MODE_BIT);
  // byte lane 0 alone carries the whole register byte
  assign wr_chan = wr_lo && (idx == sar_adc_pkg::IDX_CHAN); // [RULE_13]
  assign wr_pf = wr_lo && (idx == sar_adc_pkg::IDX_PF_MODE);
  assign wr_thresh = wr_lo && (idx == sar_adc_pkg::IDX_THRESH);

  logic [7:0] mode_reg;
  logic [7:0] chan_reg;
  logic [7:0] pf_reg;
  logic [7:0] thresh_reg;
  logic [7:0] result_reg;
  logic [7:0] bit_set;

  always_comb begin
    bit_set = mode_reg;
    bit_set[writedata[2:0]] = writedata[sar_adc_pkg::BITOP_VAL_POS];
  end

  // mode register: byte write or single-bit alias
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= sar_adc_pkg::MODE_RESET; // [RULE_12]
    end else if (wr_mode) begin
      mode_reg <= writedata[7:0] & sar_adc_pkg::MODE_MASK;
    end else if (wr_mode_bit) begin
      mode_reg <= bit_set & sar_adc_pkg::MODE_MASK; // [RULE_12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg <= sar_adc_pkg::CHAN_RESET; // [RULE_13]
    end else if (wr_chan) begin
      chan_reg <= writedata[7:0] & sar_adc_pkg::CHAN_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_reg <= sar_adc_pkg::PF_RESET;
      thresh_reg <= sar_adc_pkg::THRESH_RESET; // [RULE_19]
    end else begin
      if (wr_pf) begin
        pf_reg <= writedata[7:0] & sar_adc_pkg::PF_MASK;
      end
      if (wr_thresh) begin
        thresh_reg <= writedata[7:0]; // [RULE_19]
      end
    end
  end

  logic conv_en;
  logic [2:0] time_code;
  logic pf_en;
  logic pf_dir;
  assign conv_en = mode_reg[sar_adc_pkg::MODE_ENABLE_POS]; // [RULE_09]
  assign time_code = mode_reg[sar_adc_pkg::MODE_TIME_LSB +: 3];
  assign pf_en = pf_reg[sar_adc_pkg::PF_ENABLE_POS]; // [RULE_17]
  assign pf_dir = pf_reg[sar_adc_pkg::PF_DIR_POS];
  assign channel_sel = chan_reg[1:0]; // [RULE_01]

  // prohibited codes fall back to the time of code 0, 144 periods
  logic [5:0] bit_cycles;
  always_comb begin
    case (time_code) // [RULE_10]
      sar_adc_pkg::TIME_120:
        bit_cycles = 6'(sar_adc_pkg::CONV_120 / sar_adc_pkg::RESULT_W);
      sar_adc_pkg::TIME_96:
        bit_cycles = 6'(sar_adc_pkg::CONV_96 / sar_adc_pkg::RESULT_W);
      sar_adc_pkg::TIME_288:
        bit_cycles = 6'(sar_adc_pkg::CONV_288 / sar_adc_pkg::RESULT_W);
      sar_adc_pkg::TIME_240:
        bit_cycles = 6'(sar_adc_pkg::CONV_240 / sar_adc_pkg::RESULT_W);
      sar_adc_pkg::TIME_192:
        bit_cycles = 6'(sar_adc_pkg::CONV_192 / sar_adc_pkg::RESULT_W);
      default:
        bit_cycles = 6'(sar_adc_pkg::CONV_144 / sar_adc_pkg::RESULT_W);
    endcase
  end

  // any write to mode or channel throws the running conversion away
  logic abort;
  assign abort = wr_mode || wr_mode_bit || wr_chan; // [RULE_20] [RULE_08]

  logic [7:0] seq_result;
  logic conv_done;
  logic busy;

  sar_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .run(conv_en),
    .abort(abort),
    .bit_cycles(bit_cycles),
    .cmp_high(sync2[4]),
    .trial(tap_code),
    .result(seq_result),
    .done(conv_done),
    .busy(busy)
  );

  // analog input is held for as long as a conversion runs
  assign sample_hold = busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= sar_adc_pkg::RESULT_RESET; // [RULE_07]
    end else if (conv_done) begin
      result_reg <= seq_result; // [RULE_06] [RULE_05]
    end
  end

  // compared against the fresh result so the request matches the value
  logic pf_hit;
  logic pf_last;
  assign pf_hit = pf_dir ? (seq_result < thresh_reg) // [RULE_18]
                         : (seq_result >= thresh_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_irq <= 1'b0;
      pf_last <= 1'b0;
    end else begin
      conversion_done_irq <= conv_done && (!pf_en || pf_hit); // [RULE_03] [RULE_04]
      if (conv_done) begin
        pf_last <= pf_hit;
      end
    end
  end

  // read mux; result has no write path at all
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      sar_adc_pkg::IDX_MODE: rd_byte = mode_reg;
      sar_adc_pkg::IDX_CHAN: rd_byte = chan_reg;
      sar_adc_pkg::IDX_PF_MODE: rd_byte = pf_reg;
      sar_adc_pkg::IDX_THRESH: rd_byte = thresh_reg;
      sar_adc_pkg::IDX_RESULT: rd_byte = result_reg; // [RULE_06]
      sar_adc_pkg::IDX_PINS: rd_byte = {4'h0, sync2[3:0]}; // [RULE_16]
      sar_adc_pkg::IDX_STATUS: rd_byte = {6'h00, pf_last, busy};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (req && !ack && read) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // checks

  sequence s_bus_answer;
    waitrequest ##1 !waitrequest;
  endsequence

  a_bus_one_wait: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(req) && !ack |-> s_bus_answer)
    else $error("bus answer not on second cycle");

  a_chan_route: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rst_n)
    wr_chan |=> channel_sel == $past(writedata[1:0]))
    else $error("channel select does not follow write");

  a_result_load: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    conv_done |=> result_reg == $past(seq_result))
    else $error("result not loaded at conversion end");

  a_irq_normal: assert property ( // [RULE_03]
    @(posedge clk) disable iff (!rst_n)
    conv_done && !pf_en |=> conversion_done_irq)
    else $error("missing request in normal mode");

  a_irq_only_done: assert property ( // [RULE_03]
    @(posedge clk) disable iff (!rst_n)
    conversion_done_irq |-> $past(conv_done))
    else $error("request without a conversion end");

  a_irq_pf_above: assert property ( // [RULE_18]
    @(posedge clk) disable iff (!rst_n)
    conv_done && pf_en && !pf_dir && seq_result < thresh_reg
      |=> !conversion_done_irq)
    else $error("request below threshold in direction 0");

  a_irq_pf_below: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rst_n)
    conv_done && pf_en && pf_dir && seq_result < thresh_reg
      |=> conversion_done_irq)
    else $error("missing request below threshold");

  sequence s_restart;
    !busy ##1 busy;
  endsequence

  a_abort_restart: assert property ( // [RULE_20]
    @(posedge clk) disable iff (!rst_n)
    abort && busy && writedata[7] && wr_mode |=> s_restart)
    else $error("conversion not restarted after mode write");

  a_stop: assert property ( // [RULE_09]
    @(posedge clk) disable iff (!rst_n)
    !conv_en |=> !busy)
    else $error("conversion runs while disabled");

  a_mode_mask: assert property ( // [RULE_12]
    @(posedge clk) disable iff (!rst_n)
    (mode_reg & ~sar_adc_pkg::MODE_MASK) == 8'h00)
    else $error("reserved mode bits set");

  a_irq_pf_at_least: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rst_n)
    conv_done && pf_en && !pf_dir && seq_result >= thresh_reg
      |=> conversion_done_irq)
    else $error("missing request at or above threshold");

  a_irq_pf_dir_high: assert property ( // [RULE_18]
    @(posedge clk) disable iff (!rst_n)
    conv_done && pf_en && pf_dir && seq_result >= thresh_reg
      |=> !conversion_done_irq)
    else $error("request at or above threshold in direction 1");

  a_result_hold: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    !conv_done |=> $stable(result_reg))
    else $error("result changed without a conversion end");

  a_thresh_load: assert property ( // [RULE_19]
    @(posedge clk) disable iff (!rst_n)
    wr_thresh |=> thresh_reg == $past(writedata[7:0]))
    else $error("threshold does not follow write");

endmodule

// >>> rtl/sar_adc_pkg.sv
package sar_adc_pkg;

  // bus address is a byte address; register byte address is 4 * index
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_MODE = 16'hff80;
  localparam logic [IDX_W-1:0] IDX_CHAN = 16'hff81;
  localparam logic [IDX_W-1:0] IDX_PF_MODE = 16'hff82;
  localparam logic [IDX_W-1:0] IDX_THRESH = 16'hff83;
  localparam logic [IDX_W-1:0] IDX_RESULT = 16'hff84;
  localparam logic [IDX_W-1:0] IDX_PINS = 16'hff85;
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'hff86;
  localparam logic [IDX_W-1:0] IDX_MODE_BIT = 16'hff87;

  localparam int RESULT_W = 8;
  localparam int CHAN_W = 2;
  localparam int NUM_CHAN = 4;
  localparam int BITCNT_W = 6;

  // converter_mode_control fields
  localparam int MODE_ENABLE_POS = 7;
  localparam int MODE_TIME_LSB = 3;
  localparam logic [7:0] MODE_MASK = 8'hb8;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // input_channel_select fields
  localparam logic [7:0] CHAN_MASK = 8'h03;
  localparam logic [7:0] CHAN_RESET = 8'h00;
  // powerfail_mode_reg fields
  localparam int PF_ENABLE_POS = 7;
  localparam int PF_DIR_POS = 6;
  localparam logic [7:0] PF_MASK = 8'hc0;
  localparam logic [7:0] PF_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // single-bit alias: writedata[2:0] bit number, writedata[3] bit value
  localparam int BITOP_VAL_POS = 3;

  // conversion time codes and durations in main-clock periods
  localparam logic [2:0] TIME_144 = 3'h0;
  localparam logic [2:0] TIME_120 = 3'h1;
  localparam logic [2:0] TIME_96 = 3'h2;
  localparam logic [2:0] TIME_288 = 3'h4;
  localparam logic [2:0] TIME_240 = 3'h5;
  localparam logic [2:0] TIME_192 = 3'h6;
  localparam int CONV_144 = 144;
  localparam int CONV_120 = 120;
  localparam int CONV_96 = 96;
  localparam int CONV_288 = 288;
  localparam int CONV_240 = 240;
  localparam int CONV_192 = 192;

  // least conversion time that software must program
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MIN_CONV_TIME_NS = 15000;
  localparam int MIN_CONV_CYCLES =
    (MIN_CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// >>> rtl/sar_seq.sv
`timescale 1ns/1ps
module sar_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic abort,
  input wire logic [5:0] bit_cycles,
  input wire logic cmp_high,
  output logic [7:0] trial,
  output logic [7:0] result,
  output logic done,
  output logic busy
);

  typedef enum logic {ST_IDLE, ST_CONV} seq_state_t;
  seq_state_t state;
  logic [5:0] cnt;
  logic [2:0] bit_idx;
  logic bit_end;
  logic [7:0] next_trial;

  assign busy = (state == ST_CONV);
  assign bit_end = busy && (cnt == 6'h00) && run && !abort;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (abort || !run) begin
      state <= ST_IDLE; // [RULE_20]
    end else begin
      case (state)
        ST_IDLE: state <= ST_CONV;
        ST_CONV: state <= ST_CONV; // [RULE_02]
        default: state <= ST_IDLE;
      endcase
    end
  end

  // per-bit share of the conversion time, reloaded at every start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
    end else if (!busy || abort || cnt == 6'h00) begin
      cnt <= bit_cycles - 6'h01; // [RULE_22] [RULE_21]
    end else begin
      cnt <= cnt - 6'h01;
    end
  end

  always_comb begin
    next_trial = trial;
    next_trial[bit_idx] = cmp_high;
    if (bit_idx != 3'h0) begin
      next_trial[bit_idx - 3'h1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial <= 8'h80;
      bit_idx <= 3'h7;
    end else if (!busy || abort) begin
      trial <= 8'h80; // [RULE_05]
      bit_idx <= 3'h7;
    end else if (bit_end) begin
      // the last decision also rearms the msb for the next conversion
      trial <= (bit_idx == 3'h0) ? 8'h80 : next_trial;
      bit_idx <= bit_idx - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= bit_end && (bit_idx == 3'h0);
      if (bit_end && bit_idx == 3'h0) begin
        result <= next_trial; // [RULE_05]
      end
    end
  end

  // helper: cycles since the conversion began
  logic [8:0] span;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      span <= 9'h000;
    end else if (!busy || done) begin
      span <= {8'h00, busy};
    end else begin
      span <= span + 9'h001;
    end
  end

  a_full_span: assert property ( // [RULE_21]
    @(posedge clk) disable iff (!rst_n)
    $rose(done) && $stable(bit_cycles) |->
      (span == {bit_cycles, 3'h0}))
    else $error("conversion length differs from selected time");

  a_msb_first: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rst_n)
    $rose(busy) |-> (trial == 8'h80) && (bit_idx == 3'h7))
    else $error("conversion does not start at the msb");

endmodule

// >>> sim/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
  input wire logic clk,
  input wire logic [3:0][7:0] level,
  input wire logic [1:0] channel_sel,
  input wire logic [7:0] tap_code,
  input wire logic sample_hold,
  output logic comparator_high,
  output logic [3:0] pins
);
  logic [7:0] held;

  // tracks the routed input until hold begins, then freezes it, so a level
  // change in mid-conversion is not seen until the next sampling phase
  always_ff @(posedge clk) begin
    if (!sample_hold) begin
      held <= level[channel_sel];
    end
  end

  assign comparator_high = (held >= tap_code);
  assign pins = {level[3][7], level[2][7], level[1][7], level[0][7]};
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [17:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] readdata;
  logic waitrequest;
  logic comparator_high;
  logic [3:0] pins;
  logic [1:0] channel_sel;
  logic [7:0] tap_code;
  logic sample_hold;
  logic conversion_done_irq;
  logic [3:0][7:0] level = '0;
  logic [31:0] expq[$];
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int durs [6] = '{144, 120, 96, 288, 240, 192};
  int fails = 0;
  int compares = 0;
  int irq_cnt = 0;
  int cyc = 0;
  int last_irq = 0;
  int seed = 32'h00c3ee57;
  int t0;
  int n;
  logic [7:0] v;

  initial forever #2.5 clk = ~clk;

  sar_adc_control_powerfail i_dut (.clk(clk), .arst_n(arst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .comparator_high(comparator_high), .analog_in_0(pins[0]),
    .analog_in_1(pins[1]), .analog_in_2(pins[2]), .analog_in_3(pins[3]),
    .channel_sel(channel_sel), .tap_code(tap_code),
    .sample_hold(sample_hold), .conversion_done_irq(conversion_done_irq));

  analog_front_model i_front (.clk(clk), .level(level),
    .channel_sel(channel_sel), .tap_code(tap_code),
    .sample_hold(sample_hold), .comparator_high(comparator_high),
    .pins(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low, released only after it
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] d, input logic be);
    int i;
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    byteenable <= {3'h0, be};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      fails++;
      $display("Error at %0t: bus answer timed out", $time);
      test_done();
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b1);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00, 1'b1);
  endtask

  task automatic wait_irq;
    int m;
    int i;
    m = irq_cnt;
    for (i = 0; i < 1000; i++) begin
      @(posedge clk);
      #1;
      if (irq_cnt != m) break;
    end
    if (i == 1000) begin
      fails++;
      $display("Error at %0t: no conversion request seen", $time);
      test_done();
    end
  endtask

  task automatic pf(input logic dir, input logic [7:0] thr, input logic exp);
    int m;
    wr(sar_adc_pkg::IDX_THRESH, thr);
    wr(sar_adc_pkg::IDX_PF_MODE, {1'b1, dir, 6'h00});
    wr(sar_adc_pkg::IDX_MODE, 8'h90);
    // a request launched just before the abort must land before counting
    repeat (2) @(posedge clk);
    m = irq_cnt;
    repeat (400) @(posedge clk);
    check({31'h0, irq_cnt > m}, {31'h0, exp});
  endtask

  // read answers are matched in order against the noted expectations
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conversion_done_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      last_irq <= cyc;
    end
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expq.size() == 0) begin
        fails++;
        $display("Error at %0t: read answer with no expectation", $time);
      end else begin
        check(readdata, expq.pop_front());
      end
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(sar_adc_pkg::IDX_MODE, 8'h00);
    rd(sar_adc_pkg::IDX_CHAN, 8'h00);
    rd(sar_adc_pkg::IDX_THRESH, 8'h00);
    rd(sar_adc_pkg::IDX_RESULT, 8'h00);
    rd(16'h0010, 8'h00);
    for (int ch = 0; ch < 4; ch++) begin
      level[ch] <= 8'($random(seed));
      wr(sar_adc_pkg::IDX_CHAN, 8'(ch));
      repeat (2) @(posedge clk);
      check({30'h0, channel_sel}, 32'(ch));
    end
    rd(sar_adc_pkg::IDX_PINS, {4'h0, level[3][7], level[2][7],
                               level[1][7], level[0][7]});
    // no code reaches the settling minimum at this clock; the model settles
    // at once, so only the cycle counts matter here
    for (int k = 0; k < 6; k++) begin
      v = 8'($random(seed));
      level[3] <= v;
      wr(sar_adc_pkg::IDX_MODE, {2'b10, codes[k], 3'b000});
      wait_irq();
      wait_irq();
      t0 = last_irq;
      wait_irq();
      check(32'(last_irq - t0), 32'(durs[k]));
      rd(sar_adc_pkg::IDX_RESULT, v);
    end
    // restart after a channel write must wait a whole conversion again
    wait_irq();
    wr(sar_adc_pkg::IDX_CHAN, 8'h03);
    t0 = cyc;
    wait_irq();
    check({31'h0, (last_irq - t0) >= 192 && (last_irq - t0) <= 196},
          32'h1);
    wr(sar_adc_pkg::IDX_MODE, 8'h30);
    n = irq_cnt;
    repeat (600) @(posedge clk);
    check(32'(irq_cnt), 32'(n));
    check({31'h0, sample_hold}, 32'h0);
    check({24'h0, tap_code}, 32'h80);
    // threshold still zero and direction 0, so the last outcome was a hit
    rd(sar_adc_pkg::IDX_STATUS, 8'h02);
    rd(sar_adc_pkg::IDX_MODE, 8'h30);
    wr(sar_adc_pkg::IDX_MODE_BIT, 8'h0f);
    rd(sar_adc_pkg::IDX_MODE, 8'hb0);
    bus(1'b1, sar_adc_pkg::IDX_MODE, 8'h00, 1'b0);
    rd(sar_adc_pkg::IDX_MODE, 8'hb0);
    wr(sar_adc_pkg::IDX_RESULT, ~v);
    rd(sar_adc_pkg::IDX_RESULT, v);
    v = 8'({$random(seed)} % 255);
    level[3] <= v;
    pf(1'b0, v, 1'b1);
    pf(1'b0, v + 8'h01, 1'b0);
    pf(1'b1, v, 1'b0);
    pf(1'b1, v + 8'h01, 1'b1);
    rd(sar_adc_pkg::IDX_PF_MODE, 8'hc0);
    test_done();
  end
endmodule
